//--- link_partner.sv
// link partner model that accepts or discards egress packets
`timescale 1ns/1ps
module link_partner (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  switch_err_pkg::dword_t egOut,
    input  wire logic             egNullify,
    output int                    goodCount,
    output int                    dropCount
);
    import switch_err_pkg::*;

    // nullified packets are thrown away at their last dword
    always_ff @(posedge clock) begin
        if (!rstn) begin
            goodCount <= 0;
            dropCount <= 0;
        end else if (egOut.valid && egOut.eop) begin
            if (egNullify) begin
                dropCount <= dropCount + 1;
            end else begin
                goodCount <= goodCount + 1;
            end
        end
    end
endmodule // link_partner

//--- sat_counter.sv
// saturating event counter with clear-on-read
`timescale 1ns/1ps
module sat_counter #(
    parameter int W = 8
) (
    input  wire logic         clock,
    input  wire logic         rstn,
    input  wire logic         inc,
    input  wire logic         clr,
    output logic [W-1:0]      count_reg
);
    logic [W-1:0] count_next;

    // clear first, then apply a coinciding increment
    always_comb begin
        count_next = count_reg;
        if (clr) begin
            count_next = '0;
        end
        if (inc && count_next != '1) begin
            count_next = count_next + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule // sat_counter

//--- switch_err_pkg.sv
// constants, register map and packed carriers of the switch error block
package switch_err_pkg;
    localparam logic [11:0] ADDR_CMD      = 12'h004;
    localparam logic [11:0] ADDR_DEVCTL   = 12'h008;
    localparam logic [11:0] ADDR_TOCTL    = 12'h010;
    localparam logic [11:0] ADDR_TOSTS    = 12'h014;
    localparam logic [11:0] ADDR_TOCNT    = 12'h018;
    localparam logic [11:0] ADDR_TORCTL   = 12'h01c;
    localparam logic [11:0] ADDR_PESTS    = 12'h020;
    localparam logic [11:0] ADDR_PECNT    = 12'h024;
    localparam logic [11:0] ADDR_PERCTL   = 12'h028;
    localparam logic [11:0] ADDR_PECTL    = 12'h02c;
    localparam logic [11:0] ADDR_SWITCH_CONTROL    = 12'h404;
    // field positions
    localparam int CMD_IO = 0, CMD_MEM = 1, CMD_MASTER = 2, CMD_SERR = 8;
    localparam int PECTL_DIS = 0, PECTL_INJ = 1, PECTL_LEN = 8;
    localparam int CNT_W = 8;
    localparam int LEN_W = 10;
    // reset values
    localparam logic [7:0] TORCTL_RST = 8'h82; // posted, inserted nonfatal
    localparam logic [1:0] PERCTL_RST = 2'h2;
    // severities of an error message
    localparam logic [1:0] SEV_NONE = 2'h0, SEV_COR = 2'h1;
    localparam logic [1:0] SEV_NF = 2'h2, SEV_FATAL = 2'h3;
    localparam logic [1:0] PORT_UP = 2'h0;
    // discard age limit
    localparam longint TIMEOUT_S = 64;
    localparam longint CLOCK_HZ = 200_000_000;
    localparam longint TIMEOUT_CYCLES = TIMEOUT_S * CLOCK_HZ;
    localparam int AGE_W = 34;

    typedef enum logic [2:0] {K_MEM, K_IO, K_CFG0, K_CFG1, K_CPL, K_MSG,
                              K_MSGVD} tlp_kind_t;
    typedef enum logic [1:0] {V_FWD, V_UR, V_UC, V_DROP} verdict_t;
    typedef struct packed {
        logic       valid;
        tlp_kind_t  kind;
        logic [1:0] ingressPort;
        logic [1:0] targetPort;
        logic       validRoute;
        logic       hitUpWin;
        logic       hitDnWin;
        logic       tgtMemEn;
        logic       tgtIoEn;
        logic       targetsSwitch;
        logic       routesBridge;
        logic       deviceExists;
        logic       convT0Dn;
        logic [4:0] devNum;
    } tlp_desc_t;
    typedef struct packed {
        logic     valid;
        verdict_t verdict;
    } route_res_t;
    typedef struct packed {
        logic             valid;
        logic [31:0]      data;
        logic             par;
        logic             eop;
        logic [LEN_W-1:0] hdrLen;
    } dword_t;
    typedef struct packed {
        logic       valid;
        logic [1:0] sev;
    } err_msg_t;
endpackage

//--- switch_error_detection.sv
// routing error verdicts, queue time-outs and end-to-end parity of a port
`timescale 1ns/1ps
module switch_error_detection #(
    parameter longint TIMEOUT_CYCLES = switch_err_pkg::TIMEOUT_CYCLES
) (
    input  wire logic                        clock,
    input  wire logic                        rstn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic [31:0]                      prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        upMasterEnable,
    input  switch_err_pkg::tlp_desc_t        desc,
    output switch_err_pkg::route_res_t       routeRes,
    input  wire logic [3:0]                  headValid,
    input  wire logic [3:0]                  headNew,
    input  wire logic                        bcastBusy,
    output logic [3:0]                       tmoDiscard,
    output logic                             bcastAbort,
    input  switch_err_pkg::dword_t           igIn,
    output switch_err_pkg::dword_t           igOut,
    input  switch_err_pkg::dword_t           updIn,
    output switch_err_pkg::dword_t           updOut,
    input  switch_err_pkg::dword_t           egIn,
    output switch_err_pkg::dword_t           egOut,
    output logic                             egNullify,
    input  switch_err_pkg::dword_t           consIn,
    output logic                             consDiscard,
    output switch_err_pkg::err_msg_t         errMsg
);
    import switch_err_pkg::*;

    localparam logic [AGE_W-1:0] AGE_LAST =
        AGE_W'(TIMEOUT_CYCLES - 1);

    logic [31:0]        cmd_reg;
    logic [3:0]         devCtl_reg;
    logic               toOff_reg;
    logic [3:0]         toSts_reg;
    logic [7:0]         toRctl_reg;
    logic               peSts_reg;
    logic [1:0]         peRctl_reg;
    logic [LEN_W+7:0]   peCtl_reg;
    logic               dzcd_reg;
    logic [CNT_W-1:0]   toCnt [4];
    logic [CNT_W-1:0]   peCnt;
    logic [AGE_W-1:0]   age_reg [4];
    logic [3:0]         tmoHit;
    logic               egErrAcc_reg;
    logic               consErrAcc_reg;
    logic               egBad;
    logic               consBad;
    logic               parEvt;
    logic [4:0]         msgPend_reg;
    logic [4:0]         rise;
    logic               setup;
    logic               wrEn;
    logic               rdHit;
    logic [31:0]        rdMux;
    logic               toClr;
    logic               peClr;
    logic               chkOn;
    verdict_t           verdict;

    // bus phases: one wait-free access cycle after setup
    assign setup = psel && !penable;
    assign wrEn  = psel && penable && pready && pwrite;
    assign toClr = setup && !pwrite && paddr == ADDR_TOCNT;
    assign peClr = setup && !pwrite && paddr == ADDR_PECNT;
    assign chkOn = !peCtl_reg[PECTL_DIS];

    // read decode
    always_comb begin
        rdHit = 1'b1;
        rdMux = 32'h0;
        case (paddr)
            ADDR_CMD:    rdMux = cmd_reg;
            ADDR_DEVCTL: rdMux = {28'h0, devCtl_reg};
            ADDR_TOCTL:  rdMux = {31'h0, toOff_reg};
            ADDR_TOSTS:  rdMux = {28'h0, toSts_reg};
            ADDR_TOCNT:  rdMux = {toCnt[3], toCnt[2], toCnt[1], toCnt[0]};
            ADDR_TORCTL: rdMux = {24'h0, toRctl_reg};
            ADDR_PESTS:  rdMux = {31'h0, peSts_reg};
            ADDR_PECNT:  rdMux = {24'h0, peCnt};
            ADDR_PERCTL: rdMux = {30'h0, peRctl_reg};
            ADDR_PECTL:  rdMux = {14'h0, peCtl_reg};
            ADDR_SWITCH_CONTROL:  rdMux = {31'h0, dzcd_reg};
            default:     rdHit = 1'b0;
        endcase
    end

    // bus answer
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !rdHit;
            if (setup && !pwrite) begin
                prdata <= rdMux;
            end
        end
    end

    // control registers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            cmd_reg    <= 32'h0;
            devCtl_reg <= 4'h0;
            toOff_reg  <= 1'b0;
            toRctl_reg <= TORCTL_RST;
            peRctl_reg <= PERCTL_RST;
            peCtl_reg  <= '0;
            dzcd_reg   <= 1'b0;
        end else if (wrEn) begin
            case (paddr)
                ADDR_CMD:    cmd_reg    <= pwdata;
                ADDR_DEVCTL: devCtl_reg <= pwdata[3:0];
                ADDR_TOCTL:  toOff_reg  <= pwdata[0];
                ADDR_TORCTL: toRctl_reg <= pwdata[7:0];
                ADDR_PERCTL: peRctl_reg <= pwdata[1:0];
                ADDR_PECTL:  peCtl_reg  <= pwdata[LEN_W+7:0];
                ADDR_SWITCH_CONTROL:  dzcd_reg   <= pwdata[0];
                default:     ;
            endcase
        end
    end

    // routing verdict
    always_comb begin
        verdict = V_FWD;
        case (desc.kind)
            K_MEM, K_IO: begin
                if (desc.targetPort == desc.ingressPort) begin
                    verdict = V_UR;
                end else if (desc.ingressPort == PORT_UP &&
                             desc.hitUpWin && !desc.hitDnWin) begin
                    verdict = V_UR;
                end else if (desc.targetPort != PORT_UP &&
                             ((desc.kind == K_MEM && !desc.tgtMemEn) ||
                              (desc.kind == K_IO && !desc.tgtIoEn))) begin
                    verdict = V_UR;
                end else if (desc.ingressPort != PORT_UP &&
                             (!cmd_reg[CMD_MASTER] ||
                              (desc.targetPort == PORT_UP &&
                               !upMasterEnable))) begin
                    verdict = V_UR;
                end
            end
            K_CFG0, K_CFG1: begin
                if (desc.ingressPort != PORT_UP || !desc.routesBridge ||
                    !desc.deviceExists) begin
                    verdict = V_UR;
                end else if (desc.convT0Dn && desc.devNum != 5'h0 &&
                             !dzcd_reg) begin
                    verdict = V_UR;
                end
            end
            K_CPL: begin
                if (desc.targetsSwitch) begin
                    verdict = V_UC;
                end else if (desc.targetPort == desc.ingressPort ||
                             !desc.validRoute) begin
                    verdict = V_UR;
                end
            end
            K_MSGVD: begin
                if (desc.targetsSwitch) begin
                    verdict = V_DROP;
                end else if (desc.targetPort == desc.ingressPort ||
                             !desc.validRoute || !desc.deviceExists) begin
                    verdict = V_UR;
                end
            end
            K_MSG: begin
                if (desc.targetsSwitch || desc.ingressPort == PORT_UP ||
                    desc.targetPort == desc.ingressPort ||
                    !desc.validRoute || !desc.deviceExists) begin
                    verdict = V_UR;
                end
            end
            default: verdict = V_UR;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            routeRes <= '0;
        end else begin
            routeRes.valid   <= desc.valid;
            routeRes.verdict <= verdict;
        end
    end

    // per-type head age: posted, non-posted, completion, inserted
    for (genvar i = 0; i < 4; i++) begin : g_age
        assign tmoHit[i] = headValid[i] && !headNew[i] && !toOff_reg &&
                           age_reg[i] == AGE_LAST;
        always_ff @(posedge clock) begin
            if (!rstn || headNew[i] || !headValid[i] || tmoHit[i]) begin
                age_reg[i] <= '0;
            end else if (!toOff_reg) begin
                age_reg[i] <= age_reg[i] + 1'b1;
            end
        end
        sat_counter #(.W(CNT_W)) u_toCnt (
            .clock     (clock),
            .rstn      (rstn),
            .inc       (tmoHit[i]),
            .clr       (toClr),
            .count_reg (toCnt[i])
        );
    end

    // discards, broadcast abort and sticky type status
    always_ff @(posedge clock) begin
        if (!rstn) begin
            tmoDiscard <= 4'h0;
            bcastAbort <= 1'b0;
            toSts_reg  <= 4'h0;
        end else begin
            tmoDiscard <= tmoHit;
            bcastAbort <= bcastBusy && |tmoHit;
            toSts_reg  <= (toSts_reg &
                           ~(wrEn && paddr == ADDR_TOSTS ?
                             pwdata[3:0] : 4'h0)) | tmoHit;
        end
    end

    // ingress parity generation with optional injection
    always_ff @(posedge clock) begin
        if (!rstn) begin
            igOut  <= '0;
            updOut <= '0;
        end else begin
            igOut     <= igIn;
            igOut.par <= ^igIn.data ^ (peCtl_reg[PECTL_INJ] &&
                         igIn.hdrLen == peCtl_reg[PECTL_LEN +: LEN_W]);
            updOut     <= updIn;
            updOut.par <= updIn.par ^ ^(updIn.data ^ igIn.data);
        end
    end

    // egress and consumed checks, error kept until end of packet
    assign egBad   = egIn.valid && chkOn && (^egIn.data != egIn.par);
    assign consBad = consIn.valid && chkOn && (^consIn.data != consIn.par);
    assign parEvt  = (egIn.valid && egIn.eop && (egErrAcc_reg || egBad)) ||
                     (consIn.valid && consIn.eop &&
                      (consErrAcc_reg || consBad));

    always_ff @(posedge clock) begin
        if (!rstn) begin
            egOut          <= '0;
            egNullify      <= 1'b0;
            consDiscard    <= 1'b0;
            egErrAcc_reg   <= 1'b0;
            consErrAcc_reg <= 1'b0;
        end else begin
            egOut     <= egIn;
            egNullify <= egIn.valid && egIn.eop &&
                         (egErrAcc_reg || egBad);
            consDiscard <= consIn.valid && consIn.eop &&
                           (consErrAcc_reg || consBad);
            if (egIn.valid) begin
                egErrAcc_reg <= !egIn.eop && (egErrAcc_reg || egBad);
            end
            if (consIn.valid) begin
                consErrAcc_reg <= !consIn.eop && (consErrAcc_reg || consBad);
            end
        end
    end

    sat_counter #(.W(CNT_W)) u_peCnt (
        .clock     (clock),
        .rstn      (rstn),
        .inc       (parEvt),
        .clr       (peClr),
        .count_reg (peCnt)
    );

    // sticky parity status, set wins over clear
    always_ff @(posedge clock) begin
        if (!rstn) begin
            peSts_reg <= 1'b0;
        end else begin
            peSts_reg <= (peSts_reg &&
                          !(wrEn && paddr == ADDR_PESTS && pwdata[0])) ||
                         parEvt;
        end
    end

    // message on status rise, pending until taken up, then sent if allowed or else dropped
    assign rise = {parEvt && !peSts_reg, tmoHit & ~toSts_reg};

    function automatic logic [1:0] sevOf(input int idx);
        sevOf = idx == 4 ? peRctl_reg : toRctl_reg[2*idx +: 2];
    endfunction

    function automatic logic allowed(input logic [1:0] sev);
        allowed = cmd_reg[CMD_SERR] && sev != SEV_NONE &&
                  devCtl_reg[sev - 2'h1];
    endfunction

    always_ff @(posedge clock) begin
        if (!rstn) begin
            msgPend_reg <= 5'h0;
            errMsg      <= '0;
        end else begin
            logic [4:0] pend;
            pend = msgPend_reg | rise;
            errMsg <= '0;
            for (int i = 0; i < 5; i++) begin
                if (pend[i] && !errMsg.valid) begin
                    pend[i] = 1'b0;
                    if (allowed(sevOf(i))) begin
                        errMsg.valid <= 1'b1;
                        errMsg.sev   <= sevOf(i);
                        break;
                    end
                end
            end
            msgPend_reg <= pend;
        end
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence egBadEop;
        egIn.valid && egIn.eop && (egBad || egErrAcc_reg);
    endsequence

    sequence injDword;
        igIn.valid && peCtl_reg[PECTL_INJ] &&
        igIn.hdrLen == peCtl_reg[PECTL_LEN +: LEN_W];
    endsequence

    back_route_ur_a: assert property (
        desc.valid && desc.kind == K_MEM &&
        desc.targetPort == desc.ingressPort
        |=> routeRes.valid && routeRes.verdict == V_UR)
        else $error("back-routed memory TLP not unsupported");
    internal_cpl_a: assert property (
        desc.valid && desc.kind == K_CPL && desc.targetsSwitch
        |=> routeRes.verdict == V_UC)
        else $error("internal completion not unexpected");
    vendor_drop_a: assert property (
        desc.valid && desc.kind == K_MSGVD && desc.targetsSwitch
        |=> routeRes.verdict == V_DROP)
        else $error("vendor message to port not dropped");
    cfg_down_ur_a: assert property (
        desc.valid && desc.kind == K_CFG0 && desc.ingressPort != PORT_UP
        |=> routeRes.verdict == V_UR)
        else $error("downstream config request accepted");
    timeout_off_a: assert property (
        toOff_reg |=> tmoDiscard == 4'h0)
        else $error("discard while time-outs disabled");
    tmo_status_a: assert property (
        tmoDiscard[0] |-> toSts_reg[0])
        else $error("discard without status bit");
    parity_status_a: assert property (
        parEvt |=> peSts_reg ##0 (peCnt != 8'h0 || $past(peClr)))
        else $error("parity event not recorded");
    egress_null_a: assert property (
        egBadEop |=> egNullify && egOut.eop)
        else $error("bad egress packet not nullified");
    inject_par_a: assert property (
        injDword |=> igOut.par != ^igOut.data)
        else $error("injected parity not inverted");
    clear_inc_a: assert property (
        peClr && parEvt |=> peCnt == 8'h1)
        else $error("increment lost on clearing read");
endmodule // switch_error_detection

//--- switch_error_detection_bench.sv
// self-checking bench of the switch error detection block
`timescale 1ns/1ps
module switch_error_detection_bench;
    import switch_err_pkg::*;
    localparam longint TO = 20;
    logic        clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        pready, pslverr, slv, egNullify, consDiscard, bcastAbort;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0]  headValid = '0, headNew = '0, tmoDiscard;
    logic [1:0]  lastSev;
    logic [15:0] seed = 16'he010;
    logic        upMasterEnable = 1'b1, bcastBusy = 1'b0;
    tlp_desc_t   desc = '0, dv;
    route_res_t  routeRes;
    dword_t      igIn = '0, igOut, updOut, egIn = '0, egOut;
    dword_t      updIn = '0, consIn = '0;
    err_msg_t    errMsg;
    int          errors = 0, nTests = 0, msgCnt = 0, nullCnt = 0;
    int          tmoCnt = 0, abtCnt = 0, good, drop, n;

    // 200 MHz core clock
    always #2.5 clock = ~clock;

    switch_error_detection #(.TIMEOUT_CYCLES(TO)) DUT (.clock, .rstn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .upMasterEnable, .desc, .routeRes, .headValid,
        .headNew, .bcastBusy, .tmoDiscard, .bcastAbort, .igIn,
        .igOut, .updIn, .updOut, .egIn, .egOut, .egNullify,
        .consIn, .consDiscard, .errMsg);

    link_partner LP (.clock, .rstn, .egOut, .egNullify,
        .goodCount(good), .dropCount(drop));

    // event counters sampled mid-cycle
    always @(negedge clock) begin
        if (errMsg.valid === 1'b1) begin
            msgCnt++;
            lastSev = errMsg.sev;
        end
        if (egNullify === 1'b1) nullCnt++;
        if (tmoDiscard[0] === 1'b1) tmoCnt++;
        if (bcastAbort === 1'b1) abtCnt++;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic tlp_desc_t mk(tlp_kind_t k, logic [1:0] i,
                                     logic m, logic t);
        return '{1'b1, k, i, 2'h1, 1'b1, 1'b1, 1'b1, m, 1'b1, t,
                 1'b1, 1'b1, 1'b0, 5'h0};
    endfunction

    task check(input logic [63:0] got, input logic [63:0] exp);
        nTests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task wrap_up;
        $display("comparisons %0d mismatches %0d", nTests, errors);
        if (errors == 0 && nTests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one apb transfer, waiting on pready with a bound
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 10);
        if (k >= 10) begin
            errors++;
            wrap_up;
        end
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task route(input tlp_desc_t d, input verdict_t v);
        @(posedge clock);
        desc <= d;
        @(posedge clock);
        desc <= '0;
        @(negedge clock);
        check({routeRes.valid, routeRes.verdict}, {1'b1, v});
    endtask

    // one ingress dword, parity expected even unless inverted
    task ig(input logic [9:0] len, input logic inv);
        logic [31:0] d;
        d = {seed, lfsr(seed)};
        seed = lfsr(lfsr(seed));
        @(posedge clock);
        igIn <= '{1'b1, d, 1'b0, 1'b1, len};
        @(posedge clock);
        igIn <= '0;
        @(negedge clock);
        check({igOut.data, igOut.par}, {d, ^d ^ inv});
    endtask

    // two-dword egress packet, last dword optionally corrupted
    task egpkt(input logic bad);
        for (n = 0; n < 2; n++) begin
            @(posedge clock);
            egIn <= '{1'b1, 32'(seed), ^seed ^ (bad && n == 1), n == 1, 10'h0};
            seed = lfsr(seed);
        end
        @(posedge clock);
        egIn <= '0;
        repeat (4) @(posedge clock);
    endtask

    // posted queue head ages from a fresh arrival
    task tmo(input logic en);
        @(posedge clock);
        headValid <= 4'h1;
        headNew <= 4'h1;
        @(posedge clock);
        headNew <= 4'h0;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (tmoDiscard[0] !== 1'b1 && n < 40);
        if (en && n >= 40) begin
            errors++;
            wrap_up;
        end
        @(posedge clock);
        headValid <= 4'h0;
        repeat (4) @(posedge clock);
    endtask

    // rewrite of a dword: new parity follows the old, errors carried along
    task upd(input logic bad);
        logic [31:0] o, w;
        o = {seed, lfsr(seed)};
        w = {lfsr(seed), seed};
        seed = lfsr(seed);
        @(posedge clock);
        igIn <= '{1'b1, o, 1'b0, 1'b1, 10'h0};
        updIn <= '{1'b1, w, ^o ^ bad, 1'b1, 10'h0};
        @(posedge clock);
        igIn <= '0;
        updIn <= '0;
        @(negedge clock);
        check({updOut.data, updOut.par}, {w, ^w ^ bad});
    endtask

    // one-dword consumed packet, discarded when its parity is bad
    task cons(input logic bad);
        @(posedge clock);
        consIn <= '{1'b1, 32'ha5, bad, 1'b1, 10'h1};
        @(posedge clock);
        consIn <= '0;
        @(negedge clock);
        check(consDiscard, bad);
        repeat (3) @(posedge clock);
    endtask

    // main sequence
    initial begin
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        rdchk(ADDR_TORCTL, 32'h82);
        rdchk(ADDR_PERCTL, 32'h2);
        rdchk(ADDR_PECTL, 32'h0);
        apb(1'b0, 12'h0fc, 32'h0);
        check(slv, 1'b1);
        apb(1'b1, ADDR_CMD, 32'h107);
        apb(1'b1, ADDR_DEVCTL, 32'h2);
        route(mk(K_MEM, PORT_UP, 1'b1, 1'b0), V_FWD);
        route(mk(K_MEM, PORT_UP, 1'b0, 1'b0), V_UR);
        route(mk(K_MEM, 2'h1, 1'b1, 1'b0), V_UR);
        route(mk(K_CFG0, 2'h2, 1'b1, 1'b0), V_UR);
        route(mk(K_CPL, PORT_UP, 1'b1, 1'b1), V_UC);
        route(mk(K_MSGVD, PORT_UP, 1'b1, 1'b1), V_DROP);
        route(mk(K_MSG, PORT_UP, 1'b1, 1'b1), V_UR);
        dv = mk(K_MEM, PORT_UP, 1'b1, 1'b0);
        dv.hitDnWin = 1'b0;
        route(dv, V_UR);
        dv = mk(K_MEM, 2'h2, 1'b1, 1'b0);
        dv.targetPort = PORT_UP;
        @(posedge clock);
        upMasterEnable <= 1'b0;
        route(dv, V_UR);
        @(posedge clock);
        upMasterEnable <= 1'b1;
        route(dv, V_FWD);
        dv = mk(K_CFG1, PORT_UP, 1'b1, 1'b0);
        dv.convT0Dn = 1'b1;
        dv.devNum = 5'h3;
        route(dv, V_UR);
        apb(1'b1, ADDR_SWITCH_CONTROL, 32'h1);
        route(dv, V_FWD);
        ig(10'h4, 1'b0);
        apb(1'b1, ADDR_PECTL, 32'h402);
        ig(10'h4, 1'b1);
        ig(10'h5, 1'b0);
        apb(1'b1, ADDR_PECTL, 32'h0);
        upd(1'b0);
        upd(1'b1);
        egpkt(1'b0);
        egpkt(1'b1);
        check(nullCnt, 1);
        check({good, drop}, {32'd1, 32'd1});
        check({msgCnt, lastSev}, {32'd1, SEV_NF});
        rdchk(ADDR_PESTS, 32'h1);
        rdchk(ADDR_PECNT, 32'h1);
        rdchk(ADDR_PECNT, 32'h0);
        egpkt(1'b1);
        check(msgCnt, 1);
        apb(1'b1, ADDR_PESTS, 32'h1);
        rdchk(ADDR_PESTS, 32'h0);
        bcastBusy <= 1'b1;
        tmo(1'b1);
        bcastBusy <= 1'b0;
        check(abtCnt, 1);
        check(n, TO + 1);
        check({msgCnt, lastSev}, {32'd2, SEV_NF});
        rdchk(ADDR_TOSTS, 32'h1);
        rdchk(ADDR_TOCNT, 32'h1);
        rdchk(ADDR_TOCNT, 32'h0);
        cons(1'b0);
        cons(1'b1);
        check({msgCnt, lastSev}, {32'd3, SEV_NF});
        rdchk(ADDR_PECNT, 32'h2);
        fork
            apb(1'b0, ADDR_PECNT, 32'h0);
            begin
                @(posedge clock);
                egIn <= '{1'b1, 32'h1, 1'b0, 1'b1, 10'h0};
                @(posedge clock);
                egIn <= '0;
            end
        join
        check(rd, 32'h0);
        rdchk(ADDR_PECNT, 32'h1);
        apb(1'b1, ADDR_PECTL, 32'h1);
        egpkt(1'b1);
        check({good, drop}, {32'd2, 32'd3});
        ig(10'h4, 1'b0);
        apb(1'b1, ADDR_TOCTL, 32'h1);
        tmo(1'b0);
        check(tmoCnt, 1);
        wrap_up;
    end
endmodule // switch_error_detection_bench
